// >>> include/sbam_params.svh
// Constants for the SDRAM bank address mapper.
// Assumes inclusion by the package and the mapper module only.
`ifndef SBAM_PARAMS_SVH
`define SBAM_PARAMS_SVH

`define SBAM_HOST_AW        27
`define SBAM_MEM_AW         13
`define SBAM_BANKS_16M      4
`define SBAM_BANKS_BIG      2
`define SBAM_GFX_SIZE_RST   27'h0000000
`define SBAM_POP_RST        4'h1
`define SBAM_COL_LSB        3
`define SBAM_BANK0_LSB      11
`define SBAM_ROW_LSB_2BANK  12
`define SBAM_ROW_LSB_4BANK  13
`define SBAM_COL_HI_16M     23
`define SBAM_COL_HI_BIG     25
`define SBAM_BANK_SPAN_LSB  23

`endif

// >>> include/sbam_pkg.sv
// Types for the SDRAM bank address mapper.
// Assumes sbam_params.svh on the include path.
package sbam_pkg;
    `include "sbam_params.svh"

    typedef enum logic [1:0] {
        SBAM_DEV_16M_2BANK,
        SBAM_DEV_BIG_2BANK,
        SBAM_DEV_BIG_4BANK
    } sbam_mode_e;

    typedef enum logic {
        SBAM_PH_ROW,
        SBAM_PH_COL
    } sbam_phase_e;

    typedef struct packed {
        logic [`SBAM_MEM_AW-1:0] mem_addr_line;
        logic                    bank_sel0;
        logic                    bank_sel1;
        logic [3:0]              chip_sel_n;
    } sbam_pins_s;
endpackage

// >>> rtl/sbam_mapper.sv
// SDRAM bank address mapper: byte address to bank chip select, bank select
// and multiplexed row/column lines.
// Assumes the command sequencer supplies the request and the phase.
`timescale 1ns/10ps

module sbam_mapper
    import sbam_pkg::*;
#(
    parameter int HOST_AW = `SBAM_HOST_AW
)(
    input  wire logic               clk_i,
    input  wire logic               srst_i,
    input  wire sbam_mode_e         mode_cfg_i,
    input  wire logic [3:0]         bank_pop_i,
    input  wire logic [HOST_AW-1:0] gfx_size_i,
    input  wire logic               req_valid_i,
    input  wire logic               req_gfx_i,
    input  wire logic [HOST_AW-1:0] req_addr_i,
    input  wire sbam_phase_e        req_phase_i,
    output logic                    out_valid_o,
    output logic                    out_err_o,
    output logic [12:0]             mem_addr_line_o,
    output logic                    bank_sel0_o,
    output logic                    bank_sel1_o,
    output logic [1:0]              chip_sel_n_o,
    output logic                    bank_select_two_n_o,
    output logic                    bank_select_three_n_o
);

    sbam_mode_e         mode_reg, mode_next;
    logic [3:0]         pop_reg, pop_next;
    logic [HOST_AW-1:0] gfx_reg, gfx_next;
    sbam_pins_s         pins_reg, pins_next;
    logic               valid_reg, valid_next;
    logic               err_reg, err_next;

    // Bank index from the physical address; 8 MB or 64 MB per bank slot
    function automatic logic [1:0] bank_of(input sbam_mode_e m,
                                           input logic [HOST_AW-1:0] a);
        if (m == SBAM_DEV_16M_2BANK)
        begin
            bank_of = a[24:23];
        end
        else
        begin
            bank_of = {1'b0, a[26]};
        end
    endfunction

    // Refusal decode; a graphics region larger than one bank spills into bank one
    function automatic logic range_bad(input sbam_mode_e m,
                                       input logic [3:0] pop,
                                       input logic carry,
                                       input logic gfx,
                                       input logic [HOST_AW-1:0] a,
                                       input logic [HOST_AW-1:0] gsize);
        logic [1:0] b;
        b = bank_of(m, a);
        range_bad = carry | ~pop[b];
        if (m != SBAM_DEV_16M_2BANK && b[1])
        begin
            range_bad = 1'b1;
        end
        if (gfx && a >= gsize)
        begin
            range_bad = 1'b1;
        end
    endfunction

    // Row/column multiplexing; bits 2..0 are never used here
    function automatic logic [12:0] mux_addr(input sbam_mode_e m,
                                             input sbam_phase_e ph,
                                             input logic [HOST_AW-1:0] a);
        mux_addr = 13'h0000;
        case (m)
            SBAM_DEV_16M_2BANK:
            begin
                if (ph == SBAM_PH_ROW)
                begin
                    mux_addr = {2'b00, a[22:12]};
                end
                else
                begin
                    mux_addr = {3'b000, a[24:23], a[10:3]};
                end
            end
            SBAM_DEV_BIG_2BANK:
            begin
                if (ph == SBAM_PH_ROW)
                begin
                    mux_addr = a[24:12];
                end
                else
                begin
                    mux_addr = {3'b000, a[26:25], a[10:3]};
                end
            end
            default:
            begin
                if (ph == SBAM_PH_ROW)
                begin
                    mux_addr = {1'b0, a[24:13]};
                end
                else
                begin
                    mux_addr = {3'b000, a[26:25], a[10:3]};
                end
            end
        endcase
    endfunction

    // Configuration is loaded only during reset so accesses see a stable map
    always_comb
    begin
        mode_next = mode_reg;
        pop_next  = pop_reg;
        gfx_next  = gfx_reg;
        if (srst_i)
        begin
            mode_next = mode_cfg_i;
            // Bit zero forced: bank zero always holds graphics
            pop_next  = bank_pop_i | `SBAM_POP_RST;
            gfx_next  = gfx_size_i;
        end
    end

    always_ff @(posedge clk_i)
    begin
        mode_reg <= mode_next;
        pop_reg  <= pop_next;
        gfx_reg  <= gfx_next;
    end

    // One extra bit catches host addresses carried past 128 MB
    logic [HOST_AW-1:0] phys;
    logic [HOST_AW:0]   sum;
    logic [1:0]         bank;
    logic               bad;

    always_comb
    begin
        // Graphics at base of bank zero, host directly above it
        if (req_gfx_i)
            sum = {1'b0, req_addr_i};
        else
            sum = {1'b0, req_addr_i} + {1'b0, gfx_reg};
        phys = sum[HOST_AW-1:0];
        bank = bank_of(mode_reg, phys);
        // Overflow past 128 MB or unpopulated bank is flagged, not driven
        bad  = range_bad(mode_reg, pop_reg, sum[HOST_AW], req_gfx_i, phys, gfx_reg);
    end

    // Address lines update even on refusal; only chip selects are withheld

    always_comb
    begin
        pins_next  = pins_reg;
        valid_next = 1'b0;
        err_next   = 1'b0;
        if (srst_i)
        begin
            pins_next  = '{mem_addr_line: 13'h0000, bank_sel0: 1'b0,
                           bank_sel1: 1'b0, chip_sel_n: 4'hf};
        end
        else if (req_valid_i)
        begin
            valid_next = ~bad;
            err_next   = bad;
            pins_next.mem_addr_line = mux_addr(mode_reg, req_phase_i, phys);
            pins_next.bank_sel0     = phys[`SBAM_BANK0_LSB];
            pins_next.bank_sel1     = (mode_reg == SBAM_DEV_BIG_4BANK)
                                      ? phys[12] : 1'b0;
            pins_next.chip_sel_n    = 4'hf;
            if (!bad)
                pins_next.chip_sel_n[bank] = 1'b0;
        end
    end

    always_ff @(posedge clk_i)
    begin
        pins_reg  <= pins_next;
        valid_reg <= valid_next;
        err_reg   <= err_next;
    end

    // Selects two and three carry address bits on the larger parts
    always_comb
    begin
        out_valid_o     = valid_reg;
        out_err_o       = err_reg;
        mem_addr_line_o = pins_reg.mem_addr_line;
        bank_sel0_o     = pins_reg.bank_sel0;
        bank_sel1_o     = pins_reg.bank_sel1;
        chip_sel_n_o    = pins_reg.chip_sel_n[1:0];
        case (mode_reg)
            SBAM_DEV_16M_2BANK:
            begin
                bank_select_two_n_o   = pins_reg.chip_sel_n[2];
                bank_select_three_n_o = pins_reg.chip_sel_n[3];
            end
            SBAM_DEV_BIG_2BANK:
            begin
                bank_select_two_n_o   = pins_reg.mem_addr_line[11];
                bank_select_three_n_o = pins_reg.mem_addr_line[12];
            end
            default:
            begin
                bank_select_two_n_o   = pins_reg.mem_addr_line[11];
                bank_select_three_n_o = pins_reg.bank_sel1;
            end
        endcase
    end

endmodule // sbam_mapper

// >>> tb/sbam_mapper_chk.sv
// Port checker for the bank address mapper.
// Assumes configuration inputs only change while reset is high.
`timescale 1ns/10ps
module sbam_mapper_chk
    import sbam_pkg::*;
#(
    parameter int HOST_AW = 27
)(
    input wire logic               clk_i,
    input wire logic               srst_i,
    input wire logic               req_valid_i,
    input wire logic               req_gfx_i,
    input wire logic [HOST_AW-1:0] req_addr_i,
    input wire sbam_phase_e        req_phase_i,
    input wire logic               out_valid_o,
    input wire logic               out_err_o,
    input wire logic [12:0]        mem_addr_line_o,
    input wire logic               bank_sel0_o,
    input wire logic [1:0]         chip_sel_n_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (srst_i);
    a_one_answer: assert property (req_valid_i |=> out_valid_o != out_err_o)
        else $error("request not answered exactly once");
    a_no_spurious: assert property (!req_valid_i |=> !out_valid_o && !out_err_o)
        else $error("answer without request");
    a_err_deselect: assert property (out_err_o |-> chip_sel_n_o == 2'b11)
        else $error("chip select on refused request");
    a_gfx_bank0: assert property (req_valid_i && req_gfx_i ##1 out_valid_o |-> chip_sel_n_o == 2'b10)
        else $error("graphics access outside bank zero");
    a_gfx_bank_sel: assert property (req_valid_i && req_gfx_i ##1 out_valid_o |-> bank_sel0_o == $past(req_addr_i[11]))
        else $error("bank select zero not from address bit 11");
    a_col_line10: assert property (req_valid_i && req_phase_i == SBAM_PH_COL ##1 out_valid_o |-> !mem_addr_line_o[10])
        else $error("column phase line 10 not low");
    a_col_low_bits: assert property (req_valid_i && req_gfx_i && req_phase_i == SBAM_PH_COL ##1 out_valid_o |-> mem_addr_line_o[7:0] == $past(req_addr_i[10:3]))
        else $error("column low lines not from bits 10 to 3");
    a_hold_lines: assert property (!req_valid_i |=> $stable(mem_addr_line_o))
        else $error("address lines moved without request");
    a_one_cs: assert property (out_valid_o |-> $onehot0(~chip_sel_n_o))
        else $error("more than one chip select low");
endmodule // sbam_mapper_chk

// >>> tb/sbam_sdram_model.sv
// Far-side memory model: reports which external banks are fitted.
// Assumes every fitted bank is a full 64-bit wide bank.
`timescale 1ns/10ps
module sbam_sdram_model (
    output logic [3:0] bank_pop_o
);
    // All sockets filled so every bank decode is reachable
    assign bank_pop_o = 4'hf;
endmodule // sbam_sdram_model

// >>> tb/sbam_mapper_tb_top.sv
// Testbench for the bank address mapper, one task per scenario.
// Assumes a 1 MB graphics region; configuration changes in reset only.
`timescale 1ns/10ps
module sbam_mapper_tb_top;
    import sbam_pkg::*;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    sbam_mode_e  mode = SBAM_DEV_16M_2BANK;
    logic [26:0] gsz = 27'h0100000;
    logic        rv = 1'b0;
    logic        rg = 1'b0;
    logic [26:0] ra = 27'h0;
    sbam_phase_e rp = SBAM_PH_ROW;
    logic [3:0]  pop;
    logic        ov, oe, b0, b1, s2, s3;
    logic [12:0] ml;
    logic [1:0]  cs;
    wire logic [20:0] got = {ov, oe, s3, s2, b1, b0, cs, ml};
    int          n_mismatch = 0;
    int          check_count = 0;
    always #20 clk = ~clk;
    sbam_sdram_model i_mem (.bank_pop_o(pop));
    sbam_mapper i_dut (.clk_i(clk), .srst_i(srst), .mode_cfg_i(mode), .bank_pop_i(pop),
        .gfx_size_i(gsz), .req_valid_i(rv), .req_gfx_i(rg), .req_addr_i(ra),
        .req_phase_i(rp), .out_valid_o(ov), .out_err_o(oe), .mem_addr_line_o(ml),
        .bank_sel0_o(b0), .bank_sel1_o(b1), .chip_sel_n_o(cs),
        .bank_select_two_n_o(s2), .bank_select_three_n_o(s3));
    task automatic chk(input logic [20:0] g, input logic [20:0] e);
        check_count++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    // Config is only latched in reset, so every mode change re-resets
    task automatic rst(input sbam_mode_e m);
        mode = m;
        srst = 1'b1;
        rv = 1'b0;
        repeat (12) @(negedge clk);
        if (m == SBAM_DEV_16M_2BANK)
            chk(got, {4'b0011, 4'b0011, 13'h0000});
        else
            chk(got, {4'b0000, 4'b0011, 13'h0000});
        srst = 1'b0;
    endtask
    task automatic rq(input logic g, input logic [26:0] a, input sbam_phase_e p);
        rv = 1'b1;
        rg = g;
        ra = a;
        rp = p;
        @(negedge clk);
    endtask
    task automatic t_16m();
        logic [26:0] a;
        logic [26:0] p;
        a = 27'h00abcd8;
        p = 27'h102b6e8;
        rq(1'b1, a, SBAM_PH_ROW);
        chk(got, {4'b1011, 1'b0, a[11], 2'b10, 2'b00, a[22:12]});
        rq(1'b1, a, SBAM_PH_COL);
        chk(got, {4'b1011, 1'b0, a[11], 2'b10, 3'b000, a[24:23], a[10:3]});
        rq(1'b0, 27'h0f2b6e8, SBAM_PH_ROW);
        chk(got, {4'b1010, 1'b0, p[11], 2'b11, 2'b00, p[22:12]});
        rq(1'b1, 27'h0100000, SBAM_PH_ROW);
        chk({ov, oe, cs, 17'h0}, {4'b0111, 17'h0});
    endtask
    task automatic t_big2();
        logic [26:0] p;
        p = 27'h17f3a48;
        rq(1'b0, 27'h16f3a48, SBAM_PH_ROW);
        chk(got, {2'b10, p[24], p[23], 1'b0, p[11], 2'b10, p[24:12]});
        p = 27'h4000000;
        rq(1'b0, 27'h3f00000, SBAM_PH_COL);
        chk(got, {4'b1000, 1'b0, p[11], 2'b01, 3'b000, p[26:25], p[10:3]});
        rq(1'b0, 27'h7f00000, SBAM_PH_ROW);
        chk({ov, oe, cs, 17'h0}, {4'b0111, 17'h0});
    endtask
    task automatic t_big4();
        logic [26:0] a;
        a = 27'h00f3a48;
        rq(1'b1, a, SBAM_PH_ROW);
        chk(got, {2'b10, a[12], 1'b0, a[12], a[11], 2'b10, 1'b0, a[24:13]});
        rq(1'b1, a, SBAM_PH_COL);
        chk(got, {2'b10, a[12], 1'b0, a[12], a[11], 2'b10, 3'b000, a[26:25], a[10:3]});
    endtask
    task automatic stop_test();
        $display("mismatches %0d checks %0d", n_mismatch, check_count);
        if (n_mismatch == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial
    begin
        rst(SBAM_DEV_16M_2BANK);
        t_16m();
        rst(SBAM_DEV_BIG_2BANK);
        t_big2();
        rst(SBAM_DEV_BIG_4BANK);
        t_big4();
        stop_test();
    end
    // About 45 cycles of tests; far longer means a hang
    initial
    begin
        #100us;
        n_mismatch++;
        stop_test();
    end
endmodule // sbam_mapper_tb_top
bind sbam_mapper sbam_mapper_chk #(.HOST_AW(HOST_AW)) i_chk (.clk_i(clk_i), .srst_i(srst_i),
    .req_valid_i(req_valid_i), .req_gfx_i(req_gfx_i), .req_addr_i(req_addr_i),
    .req_phase_i(req_phase_i), .out_valid_o(out_valid_o), .out_err_o(out_err_o),
    .mem_addr_line_o(mem_addr_line_o), .bank_sel0_o(bank_sel0_o), .chip_sel_n_o(chip_sel_n_o));
